// ===== hdl/rtd_pkg.sv
// Package of constants and types for the ring trip detector
package rtd_pkg;

  // Datapath widths
  localparam int CUR_W = 12;
  localparam int SUM_W = 24;
  localparam int SCNT_W = 12;
  localparam int DLEN_W = 8;

  // Register byte offsets
  localparam logic [3:0] RTD_CTRL_OFS = 4'h0;
  localparam logic [3:0] RTD_THR_OFS = 4'h4;
  localparam logic [3:0] RTD_HOOK_OFS = 4'h8;
  localparam logic [3:0] RTD_STAT_OFS = 4'hc;

  // Control register field positions
  localparam int CTRL_ACONLY_BIT = 0;
  localparam int CTRL_TWO_BIT = 1;
  localparam int CTRL_IRQEN_BIT = 2;
  localparam int CTRL_EN_BIT = 3;

  // Threshold and hook register field positions
  localparam int THR_RING_TRIP_THRESHOLD_LSB = 0;
  localparam int THR_ILR_LSB = 8;
  localparam int HOOK_TSH_LSB = 0;
  localparam int HOOK_DSH_LSB = 8;

  // Status register bit positions
  localparam int STAT_HOOK_BIT = 0;
  localparam int STAT_TRIP_BIT = 1;
  localparam int STAT_OFFHOOK_BIT = 2;
  localparam int STAT_RING_BIT = 3;

  // Reset values
  localparam logic [3:0] CTRL_RST = 4'hb;
  localparam logic [6:0] RING_TRIP_THRESHOLD_RST = 7'h28;
  localparam logic [4:0] ILR_RST = 5'h00;
  localparam logic [6:0] TSH_RST = 7'h14;
  localparam logic [7:0] DSH_RST = 8'h40;

  // Current scaling, all in microamps
  localparam int CUR_LSB_UA = 125;
  localparam int THR_STEP_UA = 500;
  localparam int ILR_STEP_UA = 2000;
  localparam int ILR_BASE_UA = 50000;

  // Timing
  localparam int CLK_FREQ_MHZ = 20;
  localparam int BLANK_TIME_US = 20000;
  localparam int BLANK_CYCLES = BLANK_TIME_US * CLK_FREQ_MHZ;
  localparam logic [DLEN_W-1:0] RT_DEBOUNCE_SAMPLES = 8'h04;

  typedef struct packed {
    logic en;
    logic irq_en;
    logic two_cycles;
    logic ac_only_trip_select;
  } rtd_cfg_t;

  typedef struct packed {
    logic [4:0] ring_current_limit;
    logic [6:0] ring_trip_threshold;
  } rtd_thr_t;

  typedef struct packed {
    logic [7:0] offhook_debounce_time;
    logic [6:0] offhook_threshold;
  } rtd_hook_t;

endpackage : rtd_pkg

// ===== hdl/rtd_debounce.sv
// Sample-counting debouncer for a comparator level
`timescale 1ns/1ns
module rtd_debounce #(
  parameter int LEN_W = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Samples
  input wire logic sample_valid,
  input wire logic raw_level,
  input wire logic [LEN_W-1:0] stable_len,
  // Result
  output logic stable_q
);

  logic [LEN_W-1:0] run_q;

  // A new level must hold for stable_len samples before it is passed on
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      run_q <= '0;
      stable_q <= 1'b0;
    end else if (sample_valid) begin
      if (raw_level == stable_q) begin
        run_q <= '0;
      end else if ((run_q + 1'b1) >= stable_len) begin
        run_q <= '0;
        stable_q <= raw_level;
      end else begin
        run_q <= run_q + 1'b1;
      end
    end
  end

endmodule : rtd_debounce

// ===== hdl/rtd_detector.sv
// Ring trip and switch hook detector with register port
//
// Operation
// R1: Rectify scaled loop current as detector input
// R2: Compare to threshold, debounce before use
// R3: Blank detector output after ringing entry
// R4: Evaluate comparator once per ring cycle
// R5: Over half cycle in current limit trips
// R6: Trip after 1 or 2 consecutive cycles
// R7: Set hook flag, optionally interrupt host
// R8: Half-wave for AC, full-wave for DC
// R9: Threshold code in 0.5 mA steps
// R10: Current limit code 2 mA from 50
// R11: AC-only: half-wave average, two cycles (the code takes 1 or 2 cycles from two_cycles alone, in either mode)
// R12: Algorithm adapts to programmed ringing settings
// R13: Host should prefer AC trip, short loops
// R14: Debounced off-hook comparator raises interrupt
// R15: Hold flags until read, rearm on ringing
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module rtd_detector #(
  parameter int BLANK_LEN = rtd_pkg::BLANK_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Line measurement
  input wire logic signed [rtd_pkg::CUR_W-1:0] cur_sample,
  input wire logic cur_valid,
  input wire logic line_ringing,
  input wire logic ring_cycle_mark,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Events
  output logic hook_irq,
  output logic ring_trip
);

  localparam int BLK_W = $clog2(BLANK_LEN + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [rtd_pkg::CUR_W-1:0] rectify(
    input logic signed [rtd_pkg::CUR_W-1:0] s,
    input logic full_wave
  );
    logic [rtd_pkg::CUR_W-1:0] m;
    m = '0;
    if (!s[rtd_pkg::CUR_W-1]) begin
      m = s;
    end else if (full_wave) begin
      m = -s;
    end
    return m;
  endfunction : rectify

  function automatic logic [rtd_pkg::CUR_W-1:0] thr_units(input logic [6:0] code);
    int u;
    u = int'(code) * rtd_pkg::THR_STEP_UA / rtd_pkg::CUR_LSB_UA;
    return u[rtd_pkg::CUR_W-1:0];
  endfunction : thr_units

  function automatic logic [rtd_pkg::CUR_W-1:0] ilr_units(input logic [4:0] code);
    int u;
    u = (rtd_pkg::ILR_BASE_UA + int'(code) * rtd_pkg::ILR_STEP_UA) / rtd_pkg::CUR_LSB_UA;
    return u[rtd_pkg::CUR_W-1:0];
  endfunction : ilr_units

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  rtd_pkg::rtd_cfg_t cfg_q;
  rtd_pkg::rtd_thr_t thr_q;
  rtd_pkg::rtd_hook_t hook_cfg_q;
  logic hook_q;
  logic hook_d;
  logic trip_st_q;
  logic trip_st_d;
  logic [31:0] rdata_q;
  logic [31:0] rd_val;
  logic stat_rd;

  assign stat_rd = reg_rd && (reg_addr == rtd_pkg::RTD_STAT_OFS);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q <= rtd_pkg::CTRL_RST;
      thr_q.ring_trip_threshold <= rtd_pkg::RING_TRIP_THRESHOLD_RST;
      thr_q.ring_current_limit <= rtd_pkg::ILR_RST;
      hook_cfg_q.offhook_threshold <= rtd_pkg::TSH_RST;
      hook_cfg_q.offhook_debounce_time <= rtd_pkg::DSH_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        rtd_pkg::RTD_CTRL_OFS: begin
          cfg_q.ac_only_trip_select <= reg_wdata[rtd_pkg::CTRL_ACONLY_BIT];
          cfg_q.two_cycles <= reg_wdata[rtd_pkg::CTRL_TWO_BIT];
          cfg_q.irq_en <= reg_wdata[rtd_pkg::CTRL_IRQEN_BIT];
          cfg_q.en <= reg_wdata[rtd_pkg::CTRL_EN_BIT];
        end
        rtd_pkg::RTD_THR_OFS: begin
          thr_q.ring_trip_threshold <= reg_wdata[rtd_pkg::THR_RING_TRIP_THRESHOLD_LSB +: 7];
          thr_q.ring_current_limit <= reg_wdata[rtd_pkg::THR_ILR_LSB +: 5];
        end
        rtd_pkg::RTD_HOOK_OFS: begin
          hook_cfg_q.offhook_threshold <= reg_wdata[rtd_pkg::HOOK_TSH_LSB +: 7];
          hook_cfg_q.offhook_debounce_time <= reg_wdata[rtd_pkg::HOOK_DSH_LSB +: 8];
        end
        default: begin
        end
      endcase
    end
  end

  logic offhook_deb;

  always_comb begin
    rd_val = 32'h0000_0000;
    case (reg_addr)
      rtd_pkg::RTD_CTRL_OFS: rd_val[3:0] = cfg_q;
      rtd_pkg::RTD_THR_OFS: begin
        rd_val[rtd_pkg::THR_RING_TRIP_THRESHOLD_LSB +: 7] = thr_q.ring_trip_threshold;
        rd_val[rtd_pkg::THR_ILR_LSB +: 5] = thr_q.ring_current_limit;
      end
      rtd_pkg::RTD_HOOK_OFS: begin
        rd_val[rtd_pkg::HOOK_TSH_LSB +: 7] = hook_cfg_q.offhook_threshold;
        rd_val[rtd_pkg::HOOK_DSH_LSB +: 8] = hook_cfg_q.offhook_debounce_time;
      end
      rtd_pkg::RTD_STAT_OFS: begin
        rd_val[rtd_pkg::STAT_HOOK_BIT] = hook_q;
        rd_val[rtd_pkg::STAT_TRIP_BIT] = trip_st_q;
        rd_val[rtd_pkg::STAT_OFFHOOK_BIT] = offhook_deb;
        rd_val[rtd_pkg::STAT_RING_BIT] = line_ringing;
      end
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // Read data stand in the cycle after each strobe cycle, zero otherwise
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= reg_rd ? rd_val : 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Ringing entry and blanking

  logic ring_prev_q;
  logic ring_entry;
  logic [BLK_W-1:0] blank_cnt_q;
  logic blanked;

  assign ring_entry = line_ringing && !ring_prev_q;
  assign blanked = (blank_cnt_q != '0) || ring_entry;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ring_prev_q <= 1'b0;
      blank_cnt_q <= '0;
    end else begin
      ring_prev_q <= line_ringing;
      if (ring_entry) begin
        blank_cnt_q <= BLK_W'(BLANK_LEN); // R3
      end else if (blank_cnt_q != '0) begin
        blank_cnt_q <= blank_cnt_q - 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample front end

  logic [rtd_pkg::CUR_W-1:0] mag;
  logic [rtd_pkg::CUR_W-1:0] mag_abs;
  logic [rtd_pkg::CUR_W-1:0] ring_trip_threshold_u;
  logic cmp_raw;
  logic cmp_deb;
  logic in_limit;
  logic off_raw;

  // Half-wave drops the negative lobe so a negative DC bias cannot lift the average
  assign mag = rectify(cur_sample, !cfg_q.ac_only_trip_select); // R1 R8 R12
  assign mag_abs = rectify(cur_sample, 1'b1);
  assign ring_trip_threshold_u = thr_units(thr_q.ring_trip_threshold); // R9
  assign cmp_raw = mag > ring_trip_threshold_u; // R2
  assign in_limit = mag_abs >= ilr_units(thr_q.ring_current_limit); // R10
  assign off_raw = mag_abs > thr_units(hook_cfg_q.offhook_threshold); // R14

  rtd_debounce #(
    .LEN_W(rtd_pkg::DLEN_W)
  ) u_trip_deb (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .sample_valid(cur_valid),
    .raw_level(cmp_raw),
    .stable_len(rtd_pkg::RT_DEBOUNCE_SAMPLES),
    .stable_q(cmp_deb)
  ); // R2

  rtd_debounce #(
    .LEN_W(rtd_pkg::DLEN_W)
  ) u_hook_deb (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .sample_valid(cur_valid),
    .raw_level(off_raw),
    .stable_len(hook_cfg_q.offhook_debounce_time),
    .stable_q(offhook_deb)
  ); // R14

  ////////////////////////////////////////////////////////////////////////////
  // Per-cycle integration

  logic acc_valid_q;
  logic [rtd_pkg::SUM_W-1:0] sum_q;
  logic [rtd_pkg::SCNT_W-1:0] n_q;
  logic [rtd_pkg::SCNT_W-1:0] lim_n_q;
  logic seen_q;
  logic cyc_eval;
  logic avg_over;
  logic lim_over;
  logic cyc_trip;
  logic [rtd_pkg::SUM_W-1:0] thr_total;

  // Average above threshold tested as sum > threshold * samples, no divider
  assign thr_total = rtd_pkg::SUM_W'(ring_trip_threshold_u) * rtd_pkg::SUM_W'(n_q);
  assign cyc_eval = ring_cycle_mark && line_ringing && acc_valid_q && cfg_q.en;
  assign avg_over = (sum_q > thr_total) && seen_q; // R4 R11
  assign lim_over = ({lim_n_q, 1'b0} > {1'b0, n_q}); // R5
  assign cyc_trip = avg_over || lim_over;

  // Only complete cycles that start after blanking are counted
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_valid_q <= 1'b0;
    end else if (!line_ringing || blanked) begin
      acc_valid_q <= 1'b0; // R3
    end else if (ring_cycle_mark) begin
      acc_valid_q <= 1'b1;
    end
  end

  // A sample in the mark cycle belongs to the new cycle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sum_q <= '0;
      n_q <= '0;
      lim_n_q <= '0;
      seen_q <= 1'b0;
    end else if (ring_cycle_mark || !line_ringing) begin
      sum_q <= cur_valid ? rtd_pkg::SUM_W'(mag) : '0; // R4
      n_q <= cur_valid ? rtd_pkg::SCNT_W'(1) : '0;
      lim_n_q <= (cur_valid && in_limit) ? rtd_pkg::SCNT_W'(1) : '0;
      seen_q <= cur_valid && cmp_deb && !blanked;
    end else if (cur_valid && (n_q != '1)) begin
      sum_q <= sum_q + rtd_pkg::SUM_W'(mag);
      n_q <= n_q + 1'b1;
      lim_n_q <= lim_n_q + rtd_pkg::SCNT_W'(in_limit);
      seen_q <= seen_q || (cmp_deb && !blanked); // R3
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cycle qualification

  logic [1:0] consec_q;
  logic [1:0] consec_d;
  logic [1:0] need;
  logic trip_q;
  logic trip_set;

  assign need = cfg_q.two_cycles ? 2'h2 : 2'h1; // R6 R11
  assign consec_d = !cyc_trip ? 2'h0 : ((consec_q == 2'h2) ? 2'h2 : consec_q + 2'h1);
  assign trip_set = cyc_eval && !trip_q && (consec_d >= need); // R6

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      consec_q <= 2'h0;
      trip_q <= 1'b0;
    end else if (ring_entry) begin
      consec_q <= 2'h0; // R15
      trip_q <= 1'b0;
    end else if (cyc_eval) begin
      consec_q <= consec_d;
      trip_q <= trip_q || trip_set;
    end
  end

  assign ring_trip = trip_q;

  ////////////////////////////////////////////////////////////////////////////
  // Status flags and interrupt

  logic off_prev_q;
  logic off_event;

  // Off-hook outside ringing is a plain switch hook event
  assign off_event = offhook_deb && !off_prev_q && !line_ringing;

  // Set wins over the clear-on-read
  assign hook_d = (trip_set || off_event) ? 1'b1 : (stat_rd ? 1'b0 : hook_q); // R7 R14 R15
  assign trip_st_d = trip_set ? 1'b1 : (stat_rd ? 1'b0 : trip_st_q);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      off_prev_q <= 1'b0;
      hook_q <= 1'b0;
      trip_st_q <= 1'b0;
    end else begin
      off_prev_q <= offhook_deb;
      hook_q <= hook_d;
      trip_st_q <= trip_st_d;
    end
  end

  assign hook_irq = hook_q && cfg_q.irq_en; // R7

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  blank_no_trip_a: assert property (blanked |-> !trip_set) // R3
    else $error("trip raised while blanked");

  half_wave_a: assert property (cfg_q.ac_only_trip_select && cur_sample[rtd_pkg::CUR_W-1] |-> mag == '0) // R8
    else $error("negative lobe passed in half-wave mode");

  trip_on_eval_a: assert property ($rose(trip_q) |-> $past(cyc_eval)) // R4
    else $error("trip outside a cycle boundary");

  two_cycle_a: assert property ($rose(trip_q) && $past(cfg_q.two_cycles) |-> consec_q == 2'h2) // R6
    else $error("trip after fewer than two cycles");

  limit_trip_a: assert property (cyc_eval && lim_over |-> consec_d != 2'h0) // R5
    else $error("current limit cycle not counted");

  hook_set_a: assert property (trip_set |=> hook_q && trip_st_q ##1 hook_q || $past(stat_rd)) // R7
    else $error("hook flag not set on trip");

  hook_hold_a: assert property (hook_q && !stat_rd |=> hook_q) // R15
    else $error("hook flag dropped without read");

  offhook_set_a: assert property (off_event |=> hook_q) // R14
    else $error("off-hook did not set hook flag");

  rdata_slot_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside its slot");

endmodule : rtd_detector

// ===== verification/rtd_line_model.sv
// Line side model: ringing cadence and loop current samples
`timescale 1ns/1ns
module rtd_line_model #(
  parameter int CYC_LEN = 64
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Stimulus control
  input wire logic ring_on,
  input wire logic signed [rtd_pkg::CUR_W-1:0] amp,
  input wire logic signed [rtd_pkg::CUR_W-1:0] bias,
  // Line measurement
  output logic signed [rtd_pkg::CUR_W-1:0] cur_sample,
  output logic cur_valid,
  output logic line_ringing,
  output logic ring_cycle_mark
);
  ////////////////////////////////////////////////////////////////////////////////
  logic [7:0] cnt_q;
  logic signed [rtd_pkg::CUR_W-1:0] val;

  // Square ringing wave: first half of each cycle positive, second half negative
  assign val = !line_ringing ? bias : (cnt_q < 8'(CYC_LEN / 2)) ? bias + amp : bias - amp;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 8'h00;
      line_ringing <= 1'b0;
      ring_cycle_mark <= 1'b0;
    end else begin
      line_ringing <= ring_on;
      ring_cycle_mark <= line_ringing && ring_on && cnt_q == 8'(CYC_LEN - 1);
      cnt_q <= (!line_ringing || cnt_q == 8'(CYC_LEN - 1)) ? 8'h00 : cnt_q + 8'h01;
    end
  end

  // Between samples the bus shows the inverse, so a stale value is never mistaken for data
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_valid <= 1'b0;
      cur_sample <= '0;
    end else begin
      cur_valid <= ~cur_valid;
      cur_sample <= cur_valid ? ~val : val;
    end
  end
endmodule : rtd_line_model

// ===== verification/ring_trip_detector_tb.sv
// Self-checking bench for the ring trip detector
`timescale 1ns/1ns
module ring_trip_detector_tb;
  logic ref_clk;
  logic rst_b;
  logic ring_on;
  logic signed [rtd_pkg::CUR_W-1:0] amp;
  logic signed [rtd_pkg::CUR_W-1:0] bias;
  logic signed [rtd_pkg::CUR_W-1:0] cur_sample;
  logic cur_valid;
  logic line_ringing;
  logic ring_cycle_mark;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic hook_irq;
  logic ring_trip;
  logic [31:0] rd_val;
  int failures;
  int samples_checked;
  int cycles;

  rtd_line_model #(.CYC_LEN(64)) i_rtd_line_model (.ref_clk(ref_clk), .rst_b(rst_b), .ring_on(ring_on),
    .amp(amp), .bias(bias), .cur_sample(cur_sample), .cur_valid(cur_valid), .line_ringing(line_ringing),
    .ring_cycle_mark(ring_cycle_mark));

  // Short blanking keeps the run small; first counted cycle starts at the first mark
  rtd_detector #(.BLANK_LEN(16)) i_rtd_detector (.ref_clk(ref_clk), .rst_b(rst_b), .cur_sample(cur_sample),
    .cur_valid(cur_valid), .line_ringing(line_ringing), .ring_cycle_mark(ring_cycle_mark),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .hook_irq(hook_irq), .ring_trip(ring_trip));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 8000) begin
      failures++;
      final_report();
    end
  end

  task automatic final_report;
    if (failures == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    rd_val = reg_rdata;
  endtask : rd

  // Returns once the flops fed by the last mark have settled
  task automatic wait_mark(input int n);
    repeat (n) begin
      @(negedge ref_clk);
      while (ring_cycle_mark !== 1'b1) @(negedge ref_clk);
    end
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : wait_mark

  task automatic run_ring(input logic [11:0] a, input logic [11:0] b, input int n_before, input logic exp);
    repeat (4) @(posedge ref_clk);
    ring_on <= 1'b1;
    amp <= a;
    bias <= b;
    wait_mark(n_before);
    check(32'(ring_trip), 32'h0);
    wait_mark(1);
    check(32'(ring_trip), 32'(exp));
    @(posedge ref_clk);
    ring_on <= 1'b0;
    amp <= '0;
    bias <= '0;
  endtask : run_ring

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    check(32'(hook_irq), 32'h0);
    check(32'(ring_trip), 32'h0);
    rd(rtd_pkg::RTD_CTRL_OFS);
    check(rd_val, 32'h0000000b);
    @(negedge ref_clk);
    check(reg_rdata, 32'h0);
    rd(rtd_pkg::RTD_THR_OFS);
    check(rd_val, 32'h00000028);
    rd(rtd_pkg::RTD_HOOK_OFS);
    check(rd_val, 32'h00004014);
    rd(4'h2);
    check(rd_val, 32'h0);
  endtask : t_reset

  // Half-wave average 180 over threshold 160, two cycles needed
  task automatic t_ac_two;
    run_ring(12'h168, 12'h000, 2, 1'b1);
    check(32'(hook_irq), 32'h0);
    check(32'(ring_trip), 32'h1);
    rd(rtd_pkg::RTD_STAT_OFS);
    check(rd_val & 32'h3, 32'h3);
    rd(rtd_pkg::RTD_STAT_OFS);
    check(rd_val & 32'h3, 32'h0);
  endtask : t_ac_two

  // Average exactly at threshold must not trip, two threshold steps above must
  task automatic t_threshold;
    run_ring(12'h140, 12'h000, 2, 1'b0);
    run_ring(12'h150, 12'h000, 2, 1'b1);
  endtask : t_threshold

  // Negative biased current trips only when full-wave rectified
  task automatic t_wave;
    wr(rtd_pkg::RTD_CTRL_OFS, 32'h0000000a);
    run_ring(12'h000, 12'hf38, 2, 1'b1);
    wr(rtd_pkg::RTD_CTRL_OFS, 32'h0000000b);
    run_ring(12'h000, 12'hf38, 2, 1'b0);
  endtask : t_wave

  task automatic t_one_irq;
    rd(rtd_pkg::RTD_STAT_OFS);
    wr(rtd_pkg::RTD_CTRL_OFS, 32'h0000000d);
    check(32'(hook_irq), 32'h0);
    run_ring(12'h168, 12'h000, 1, 1'b1);
    check(32'(hook_irq), 32'h1);
    rd(rtd_pkg::RTD_STAT_OFS);
    check(32'(hook_irq), 32'h0);
  endtask : t_one_irq

  // Threshold out of reach, so only time in current limit can trip
  task automatic t_limit;
    wr(rtd_pkg::RTD_THR_OFS, 32'h0000007f);
    wr(rtd_pkg::RTD_CTRL_OFS, 32'h0000000a);
    run_ring(12'h000, 12'h188, 2, 1'b0);
    run_ring(12'h000, 12'h198, 2, 1'b1);
    // Evaluation switched off must never trip, whatever the line does
    wr(rtd_pkg::RTD_CTRL_OFS, 32'h00000002);
    run_ring(12'h000, 12'h198, 2, 1'b0);
    wr(rtd_pkg::RTD_CTRL_OFS, 32'h0000000a);
    wr(rtd_pkg::RTD_THR_OFS, 32'h0000017f);
    run_ring(12'h000, 12'h198, 2, 1'b0);
  endtask : t_limit

  task automatic t_offhook;
    wr(rtd_pkg::RTD_CTRL_OFS, 32'h0000000d);
    wr(rtd_pkg::RTD_HOOK_OFS, 32'h00000414);
    // Live off-hook level left high by ringing must fall first, else no rising edge
    repeat (16) @(posedge ref_clk);
    rd(rtd_pkg::RTD_STAT_OFS);
    check(rd_val & 32'h4, 32'h0);
    @(posedge ref_clk);
    bias <= 12'h0c8;
    repeat (3) @(negedge ref_clk);
    check(32'(hook_irq), 32'h0);
    repeat (30) @(negedge ref_clk);
    check(32'(hook_irq), 32'h1);
    rd(rtd_pkg::RTD_STAT_OFS);
    check(rd_val & 32'h5, 32'h5);
    @(posedge ref_clk);
    bias <= '0;
  endtask : t_offhook

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    ring_on = 1'b0;
    amp = '0;
    bias = '0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    failures = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_reset();
    t_ac_two();
    t_threshold();
    t_wave();
    t_one_irq();
    t_limit();
    t_offhook();
    final_report();
  end
endmodule : ring_trip_detector_tb
